/* File: pkg/gpp_pkg.sv */
// Register map, field positions and constants of the GPIO port block.
package gpp_pkg;
   localparam int unsigned PORT_W        = 8;
   localparam int unsigned NUM_EXT       = 3;
   localparam int unsigned IDX_W         = 6;
   // Printed offsets are register indices; byte address is four times the index.
   localparam logic [IDX_W-1:0] IDX_PORT0_DATA  = 6'h00;
   localparam logic [IDX_W-1:0] IDX_PORT1_DATA  = 6'h01;
   localparam logic [IDX_W-1:0] IDX_PORT2_DATA  = 6'h02;
   localparam logic [IDX_W-1:0] IDX_EXT_IRQ0    = 6'h07;
   localparam logic [IDX_W-1:0] IDX_EXT_IRQ1    = 6'h08;
   localparam logic [IDX_W-1:0] IDX_EXT_IRQ2    = 6'h09;
   localparam logic [IDX_W-1:0] IDX_P0_CFG      = 6'h20;
   localparam logic [IDX_W-1:0] IDX_P1_CFG      = 6'h28;
   localparam logic [IDX_W-1:0] IDX_P2_CFG      = 6'h30;
   localparam logic [IDX_W-1:0] IDX_MODE        = 6'h38;
   localparam logic [IDX_W-1:0] IDX_IRQ_STATUS  = 6'h39;
   // Configuration byte fields, common to every pin.
   localparam int unsigned CFG_OE        = 0;
   localparam int unsigned CFG_PULLUP    = 1;
   localparam int unsigned CFG_OD        = 2;
   localparam int unsigned CFG_HISINK    = 3;
   localparam int unsigned CFG_TTL       = 4;
   localparam int unsigned CFG_ACT_LOW   = 5;
   localparam int unsigned CFG_INT_EN    = 6;
   localparam int unsigned CFG_ALT       = 7;
   // Mode register fields.
   localparam int unsigned MODE_USB_EN   = 0;
   localparam int unsigned MODE_FORCE    = 1;
   localparam int unsigned MODE_SPI_EN   = 2;
   localparam int unsigned MODE_REG_DRV  = 3;
   localparam logic [7:0]  CFG_RESET     = 8'h00;
   localparam logic [7:0]  DATA_RESET    = 8'h00;
   localparam logic [7:0]  P2_DATA_MASK  = 8'h03;
   localparam logic [7:0]  EXT_CFG_MASK  = 8'h77;
   localparam logic [7:0]  P1_HISINK_OK  = 8'hF8;
   localparam logic [7:0]  P1_SERIAL     = 8'h78;
   localparam logic [7:0]  P1_REGOUT     = 8'h04;
   localparam logic [7:0]  P1_USB        = 8'h03;
   localparam int unsigned EXT_PIN0      = 2;
endpackage : gpp_pkg

/* File: rtl/gpp_pin_cell.sv */
// One GPIO pin: synchroniser, edge detector and pad control.
`timescale 1ns/1ns
module gpp_pin_cell (
   input  wire logic clk_sys,
   input  wire logic rst,
   input  wire logic pad_in,
   input  wire logic data_bit,
   input  wire logic [7:0] cfg,
   input  wire logic alt_active,
   input  wire logic alt_oe,
   input  wire logic alt_out,
   output logic      level,
   output logic      edge_evt,
   output logic      pad_out,
   output logic      pad_oe_n,
   output logic      pull_en,
   output logic      ttl_sel,
   output logic      high_sink
);
   logic sync_a;
   logic sync_b;
   logic drive_en;
   logic drive_val;

   always_ff @(posedge clk_sys or posedge rst) begin // R22
      if (rst) begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
         level  <= 1'b0;
      end else begin
         sync_a <= pad_in;
         sync_b <= sync_a;
         level  <= sync_b;
      end
   end

   // Edge is seen on the pin itself, so a driven output raises it too.
   always_comb begin
      edge_evt = 1'b0; // R3
      if (cfg[gpp_pkg::CFG_INT_EN]) begin
         if (cfg[gpp_pkg::CFG_ACT_LOW]) begin
            edge_evt = level & ~sync_b; // R5
         end else begin
            edge_evt = ~level & sync_b; // R5
         end
      end
   end

   always_comb begin
      drive_en  = alt_active ? alt_oe : cfg[gpp_pkg::CFG_OE]; // R10 R11
      drive_val = alt_active ? alt_out : data_bit; // R1
      if (cfg[gpp_pkg::CFG_OD]) begin
         drive_en = drive_en & ~drive_val; // R8
      end
   end

   assign pad_out   = drive_val;
   assign pad_oe_n  = ~drive_en;
   assign pull_en   = cfg[gpp_pkg::CFG_PULLUP]; // R9 R19
   assign ttl_sel   = cfg[gpp_pkg::CFG_TTL]; // R6
   assign high_sink = cfg[gpp_pkg::CFG_HISINK];
endmodule // gpp_pin_cell

/* File: rtl/gpp_gpio_port.sv */
// GPIO ports 0 to 2 with APB register file and dedicated interrupt pins.
//
// Requirements on this block and its firmware
// R1: Data write sets driven value on enabled pins.
// R2: Data read returns present pin levels.
// R3: Interrupt enable gates each pin interrupt.
// R4: Edge interrupts; shared one rearms when all inactive.
// R5: Polarity bit picks falling or rising edge.
// R6: Threshold bit selects TTL or CMOS.
// R7: High sink only on port 1 pins 3-7.
// R8: Open drain: one floats, zero drives low.
// R9: Pull-up bit connects pull-up to supply.
// R10: Output enable turns driver on or off.
// R11: Shared pins are plain I/O when select clear.
// R12: Regulator drive sources high from regulator.
// R13: Firmware enables regulator separately.
// R14: USB mode gives port 1 bits 1:0 away.
// R15: Force state writes set D- and D+ directly.
// R16: Port 0 pins 2-4 give three separate interrupts.
// R17: Firmware clears output enable for interrupt input.
// R18: Output-driven active edge raises the interrupt.
// R19: Settings govern pin in either use.
// R20: Firmware disables, reconfigures, clears pending.
// R21: Firmware re-enables only after clearing.
// R22: Pin inputs pass a two-stage synchroniser.
`timescale 1ns/1ns
module gpp_gpio_port #(
   parameter int unsigned NPINS = 24
) (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [23:0] pad_in,
   output logic [23:0]      pad_out,
   output logic [23:0]      pad_oe_n,
   output logic [23:0]      pad_pull_en,
   output logic [23:0]      pad_ttl_sel,
   output logic [23:0]      pad_high_sink,
   output logic [23:0]      pad_reg_drive,
   output logic             regulator_output_en,
   input  wire logic [3:0]  serial_oe,
   input  wire logic [3:0]  serial_out,
   output logic             usb_mode,
   output logic [1:0]       usb_force_lines,
   output logic             usb_force_en,
   output logic [2:0]       ext_irq,
   output logic             gpio_irq
);
   if (NPINS != 3 * gpp_pkg::PORT_W) begin : g_chk
      $error("NPINS must be three ports of eight pins");
   end

   logic [7:0]  data_q [3];
   logic [7:0]  cfg_q  [NPINS];
   logic [7:0]  mode_q;
   logic [23:0] level;
   logic [23:0] edge_evt;
   logic [23:0] alt_active;
   logic [23:0] alt_oe;
   logic [23:0] alt_out;
   logic [23:0] shared_evt;
   logic [23:0] raw_high_sink;
   logic        armed;
   logic [2:0]  ext_pend;
   logic        wr_acc;
   logic        rd_acc;
   logic [5:0]  idx;
   logic        hit;
   logic [31:0] next_rdata;
   // The dedicated interrupt pins have their own vectors and never feed the shared interrupt.
   localparam logic [23:0] SHARED_MASK = ~(((24'h1 << gpp_pkg::NUM_EXT) - 24'h1) << gpp_pkg::EXT_PIN0);

   // Maps a register index to a configuration slot; returns NPINS when none.
   function automatic int unsigned cfg_slot(input logic [5:0] i);
      if (i >= gpp_pkg::IDX_P0_CFG && i < gpp_pkg::IDX_P0_CFG + 6'd8) begin
         return 32'(i - gpp_pkg::IDX_P0_CFG);
      end
      if (i >= gpp_pkg::IDX_P1_CFG && i < gpp_pkg::IDX_P1_CFG + 6'd8) begin
         return 32'(i - gpp_pkg::IDX_P1_CFG) + 8;
      end
      if (i >= gpp_pkg::IDX_P2_CFG && i < gpp_pkg::IDX_P2_CFG + 6'd8) begin
         return 32'(i - gpp_pkg::IDX_P2_CFG) + 16;
      end
      if (i >= gpp_pkg::IDX_EXT_IRQ0 && i <= gpp_pkg::IDX_EXT_IRQ2) begin
         return 32'(i - gpp_pkg::IDX_EXT_IRQ0) + gpp_pkg::EXT_PIN0;
      end
      return NPINS;
   endfunction

   assign idx     = paddr[7:2];
   assign wr_acc  = psel & penable & pwrite & pstrb[0];
   assign rd_acc  = psel & penable & ~pwrite;
   assign pready  = 1'b1;
   assign hit     = (paddr[11:8] == 4'h0)
                    && ((idx <= gpp_pkg::IDX_PORT2_DATA) || (idx == gpp_pkg::IDX_MODE)
                    || (idx == gpp_pkg::IDX_IRQ_STATUS) || (cfg_slot(idx) != NPINS));
   assign pslverr = psel & penable & ~hit;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         for (int p = 0; p < 3; p++) begin
            data_q[p] <= gpp_pkg::DATA_RESET;
         end
      end else if (wr_acc && paddr[11:8] == 4'h0 && idx <= gpp_pkg::IDX_PORT2_DATA) begin
         data_q[idx[1:0]] <= (idx == gpp_pkg::IDX_PORT2_DATA) ? (pwdata[7:0] & gpp_pkg::P2_DATA_MASK)
                                                             : pwdata[7:0]; // R1 R15 R18
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         for (int k = 0; k < NPINS; k++) begin
            cfg_q[k] <= gpp_pkg::CFG_RESET;
         end
      end else if (wr_acc && paddr[11:8] == 4'h0 && cfg_slot(idx) != NPINS) begin
         if (idx >= gpp_pkg::IDX_EXT_IRQ0 && idx <= gpp_pkg::IDX_EXT_IRQ2) begin
            cfg_q[cfg_slot(idx)] <= (cfg_q[cfg_slot(idx)] & ~gpp_pkg::EXT_CFG_MASK)
                                    | (pwdata[7:0] & gpp_pkg::EXT_CFG_MASK);
         end else begin
            cfg_q[cfg_slot(idx)] <= pwdata[7:0];
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         mode_q <= 8'h00;
      end else if (wr_acc && paddr[11:8] == 4'h0 && idx == gpp_pkg::IDX_MODE) begin
         mode_q <= pwdata[7:0];
      end
   end

   // Alternate-function ownership of the shared pins of port 1.
   genvar g;
   for (g = 0; g < NPINS; g++) begin : g_pin
      logic in_p1;
      assign in_p1 = (g >= 8) && (g < 16);
      if (g >= 11 && g <= 14) begin : g_ser
         assign alt_active[g] = mode_q[gpp_pkg::MODE_SPI_EN] & cfg_q[g][gpp_pkg::CFG_ALT]; // R11
         assign alt_oe[g]     = serial_oe[g-11];
         assign alt_out[g]    = serial_out[g-11];
         assign pad_reg_drive[g] = mode_q[gpp_pkg::MODE_REG_DRV]; // R12
      end else if (g == 10) begin : g_reg
         assign alt_active[g] = cfg_q[g][gpp_pkg::CFG_ALT]; // R11
         assign alt_oe[g]     = 1'b0;
         assign alt_out[g]    = 1'b0;
         assign pad_reg_drive[g] = 1'b0;
      end else if (g == 8 || g == 9) begin : g_usb
         // In USB mode the transceiver owns the pad; force state drives it from the data bits.
         assign alt_active[g] = mode_q[gpp_pkg::MODE_USB_EN]; // R14
         assign alt_oe[g]     = mode_q[gpp_pkg::MODE_FORCE]; // R15
         assign alt_out[g]    = data_q[1][g-8];
         assign pad_reg_drive[g] = 1'b0;
      end else begin : g_plain
         assign alt_active[g] = 1'b0;
         assign alt_oe[g]     = 1'b0;
         assign alt_out[g]    = 1'b0;
         assign pad_reg_drive[g] = 1'b0;
      end
      assign pad_high_sink[g] = in_p1 & gpp_pkg::P1_HISINK_OK[g-8 >= 0 ? (g % 8) : 0]
                                & raw_high_sink[g]; // R7
      gpp_pin_cell u_cell (
         .clk_sys    (clk_sys),
         .rst        (rst),
         .pad_in     (pad_in[g]),
         .data_bit   (data_q[g/8][g%8]),
         .cfg        (cfg_q[g]),
         .alt_active (alt_active[g]),
         .alt_oe     (alt_oe[g]),
         .alt_out    (alt_out[g]),
         .level      (level[g]),
         .edge_evt   (edge_evt[g]),
         .pad_out    (pad_out[g]),
         .pad_oe_n   (pad_oe_n[g]),
         .pull_en    (pad_pull_en[g]),
         .ttl_sel    (pad_ttl_sel[g]),
         .high_sink  (raw_high_sink[g])
      );
      // Active level of a shared source, for rearming.
      assign shared_evt[g] = cfg_q[g][gpp_pkg::CFG_INT_EN]
                             & (level[g] ^ cfg_q[g][gpp_pkg::CFG_ACT_LOW]);
   end

   assign regulator_output_en = cfg_q[10][gpp_pkg::CFG_ALT];
   assign usb_mode        = mode_q[gpp_pkg::MODE_USB_EN];
   assign usb_force_en    = mode_q[gpp_pkg::MODE_FORCE];
   assign usb_force_lines = data_q[1][1:0];

   // Dedicated pins bypass the shared interrupt and go out through one register, one per vector.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ext_irq <= 3'b000;
      end else begin
         ext_irq <= edge_evt[gpp_pkg::EXT_PIN0 +: gpp_pkg::NUM_EXT]; // R16 R18
      end
   end

   // Shared interrupt: one pulse per arming, rearmed once all sources are inactive.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         armed    <= 1'b1;
         gpio_irq <= 1'b0;
      end else begin
         gpio_irq <= 1'b0;
         if (armed && (|(edge_evt & SHARED_MASK))) begin
            gpio_irq <= 1'b1; // R4
            armed    <= 1'b0;
         end else if (!armed && !(|(shared_evt & SHARED_MASK))) begin
            armed    <= 1'b1; // R4
         end
      end
   end
   assign ext_pend = 3'b000;

   always_comb begin
      next_rdata = 32'h0000_0000;
      if (idx <= gpp_pkg::IDX_PORT2_DATA) begin
         next_rdata[7:0] = level[idx[1:0]*8 +: 8]; // R2
         if (idx == gpp_pkg::IDX_PORT2_DATA) begin
            next_rdata[7:0] = level[16 +: 8] & gpp_pkg::P2_DATA_MASK;
         end
      end else if (idx == gpp_pkg::IDX_MODE) begin
         next_rdata[7:0] = mode_q;
      end else if (idx == gpp_pkg::IDX_IRQ_STATUS) begin
         next_rdata[7:0] = {7'h00, armed};
      end else if (cfg_slot(idx) != NPINS) begin
         next_rdata[7:0] = cfg_q[cfg_slot(idx)];
         if (idx >= gpp_pkg::IDX_EXT_IRQ0 && idx <= gpp_pkg::IDX_EXT_IRQ2) begin
            next_rdata[7:0] = cfg_q[cfg_slot(idx)] & gpp_pkg::EXT_CFG_MASK;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= next_rdata;
      end
   end
endmodule // gpp_gpio_port

/* File: tb/gpp_pin_model.sv */
// Behavioural pins: external drivers, pull-ups and floating lines.
`timescale 1ns/1ns
module gpp_pin_model (
   input  wire logic        clk_sys,
   input  wire logic [23:0] pad_out,
   input  wire logic [23:0] pad_oe_n,
   input  wire logic [23:0] pad_pull_en,
   input  wire logic [23:0] ext_en,
   input  wire logic [23:0] ext_val,
   output logic [23:0]      pad_in
);
   // A floating line toggles every cycle, so a stale level can never pass a check.
   logic [23:0] flt = 24'h0;
   always @(posedge clk_sys) flt <= ~flt;
   assign pad_in = (~pad_oe_n & pad_out)
                 | (pad_oe_n & ext_en & ext_val)
                 | (pad_oe_n & ~ext_en & (pad_pull_en | flt));
endmodule // gpp_pin_model

/* File: tb/gpp_gpio_port_assertions.sv */
// Port-level checks of the GPIO port block.
`timescale 1ns/1ns
module gpp_gpio_port_chk #(
   parameter int unsigned NPINS = 24
) (
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic [23:0] pad_in,
   input wire logic [23:0] pad_oe_n,
   input wire logic [23:0] pad_high_sink,
   input wire logic [23:0] pad_reg_drive,
   input wire logic [1:0]  usb_force_lines,
   input wire logic [2:0]  ext_irq,
   input wire logic        gpio_irq
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   logic [3:0] since_p2;
   logic       last_p2;
   // Age of the last change on pin 2; its interrupt may only follow a recent edge.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         since_p2 <= 4'hF;
         last_p2  <= 1'b0;
      end else begin
         last_p2  <= pad_in[2];
         since_p2 <= (pad_in[2] != last_p2) ? 4'h0 : ((since_p2 == 4'hF) ? 4'hF : since_p2 + 4'h1);
      end
   end
   ready_access_a: assert property (psel && penable |-> pready) else $error("pready low");
   sink_pins_a: assert property ((pad_high_sink & 24'hFF07FF) == 24'h0) else $error("high sink pin");
   reg_pins_a: assert property ((pad_reg_drive & 24'hFF87FF) == 24'h0) else $error("reg drive pin");
   ext_pulse_a: assert property (ext_irq[0] |=> !ext_irq[0]) else $error("ext pulse long");
   ext_cause_a: assert property (ext_irq[0] |-> since_p2 <= 4'h7) else $error("ext irq no edge");
   shared_pulse_a: assert property ($rose(gpio_irq) |=> $fell(gpio_irq)) else $error("shared pulse long");
   rdata_hold_a: assert property (!(psel && !pwrite) |=> $stable(prdata)) else $error("prdata moved");
   force_lines_a: assert property (psel && penable && pwrite && pstrb[0] && paddr == 12'h004
      |=> usb_force_lines == $past(pwdata[1:0])) else $error("force lines");
   oe_reset_a: assert property ($fell(rst) |-> pad_oe_n == 24'hFFFFFF) else $error("oe at reset");
   cover property (ext_irq[0]);
   cover property (gpio_irq);
   cover property (psel && penable && pwrite && paddr == 12'h004);
endmodule // gpp_gpio_port_chk
bind gpp_gpio_port gpp_gpio_port_chk #(.NPINS(NPINS)) u_chk (.clk_sys(clk_sys), .rst(rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
   .pready(pready), .pad_in(pad_in), .pad_oe_n(pad_oe_n), .pad_high_sink(pad_high_sink),
   .pad_reg_drive(pad_reg_drive), .usb_force_lines(usb_force_lines), .ext_irq(ext_irq), .gpio_irq(gpio_irq));

/* File: tb/gpp_gpio_port_test.sv */
// Self-checking bench for the GPIO port block.
`timescale 1ns/1ns
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_count++; $display("[ERR] %0t %0h %0h", $time, a, e); end end
module gpp_gpio_port_test;
   logic        clk_sys = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic [7:0]  srl = 8'h0, c, d;
   logic [23:0] ext_en = 24'h0, ext_val = 24'h0, pad_in, pad_out, pad_oe_n, pull, ttl, sink, regd;
   logic        pready, pslverr, e, usb_mode, usb_force_en, gpio_irq, reg_en;
   logic [1:0]  usb_lines;
   logic [2:0]  ext_irq;
   logic [5:0]  rv [7] = '{6'h07, 6'h08, 6'h09, 6'h20, 6'h28, 6'h30, 6'h38};
   logic [7:0]  im [3] = '{8'h40, 8'h20, 8'h60};
   int          err_count = 0, num_checks = 0, seed = 64800;
   gpp_gpio_port #(.NPINS(24)) uut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pull_en(pull),
      .pad_ttl_sel(ttl), .pad_high_sink(sink), .pad_reg_drive(regd), .regulator_output_en(reg_en),
      .serial_oe(srl[7:4]), .serial_out(srl[3:0]), .usb_mode(usb_mode), .usb_force_lines(usb_lines),
      .usb_force_en(usb_force_en), .ext_irq(ext_irq), .gpio_irq(gpio_irq));
   gpp_pin_model pins (.clk_sys(clk_sys), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pull_en(pull),
      .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));
   initial forever #2 clk_sys = ~clk_sys;
   always @(posedge clk_sys) srl <= 8'($random(seed));
   function automatic logic drv(logic [7:0] f, logic b);
      return f[gpp_pkg::CFG_OE] && !(f[gpp_pkg::CFG_OD] && b);
   endfunction
   function automatic logic lvl(logic [7:0] f, logic b, logic x);
      return drv(f, b) ? b : (f[gpp_pkg::CFG_PULLUP] ? 1'b1 : x);
   endfunction
   task automatic stop_test;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [5:0] idx, input logic [7:0] wd);
      int   n;
      logic r;
      @(posedge clk_sys);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= {4'h0, idx, 2'b00};
      pwdata <= {24'h0, wd};
      @(posedge clk_sys);
      penable <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk_sys);
         r = pready;
         if (r === 1'b1) begin
            q = prdata;
            e = pslverr;
            break;
         end
      end
      psel    <= 1'b0;
      penable <= 1'b0;
      @(negedge clk_sys);
      if (n == 40) begin
         err_count++;
         stop_test();
      end
   endtask
   task automatic see_irq(input int b, input logic x);
      logic       hit;
      logic [3:0] v;
      hit = 1'b0;
      repeat (10) begin
         @(negedge clk_sys);
         v = {gpio_irq, ext_irq};
         hit = hit | v[b];
      end
      `CHK(hit, x)
   endtask
   initial begin
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      foreach (rv[i]) begin
         apb(0, rv[i], 8'h00);
         `CHK(q, 32'h0)
      end
      apb(1, 6'h3F, 8'hFF);
      `CHK(e, 1'b1)
      apb(0, 6'h3F, 8'h00);
      `CHK({e, q}, 33'h100000000)
      apb(1, gpp_pkg::IDX_EXT_IRQ0, 8'hFF);
      apb(0, gpp_pkg::IDX_EXT_IRQ0, 8'h00);
      `CHK(q, 32'h77)
      apb(0, gpp_pkg::IDX_PORT2_DATA, 8'h00);
      `CHK(q & 32'hFFFFFFFC, 32'h0)
      repeat (20) begin
         c = 8'($random(seed)) & 8'h1F;
         d = 8'($random(seed));
         ext_val[7] <= d[0];
         ext_en[7]  <= !drv(c, d[7]) && !c[gpp_pkg::CFG_PULLUP];
         apb(1, gpp_pkg::IDX_P0_CFG + 6'h07, c);
         apb(1, gpp_pkg::IDX_PORT0_DATA, d);
         repeat (4) @(posedge clk_sys);
         apb(0, gpp_pkg::IDX_PORT0_DATA, 8'h00);
         `CHK(q[7], lvl(c, d[7], d[0]))
         `CHK(pad_oe_n[7], !drv(c, d[7]))
         `CHK(pad_out[7], d[7])
         `CHK({pull[7], ttl[7], sink[7]}, {c[1], c[4], 1'b0})
      end
      apb(1, gpp_pkg::IDX_P1_CFG + 6'h03, 8'h08);
      `CHK(sink[11], 1'b1)
      ext_en[4:2]  <= 3'b111;
      ext_val[4:2] <= 3'b000;
      for (int i = 0; i < 3; i++) begin
         foreach (im[m]) begin
            apb(1, gpp_pkg::IDX_P0_CFG + 6'(2 + i), im[m] & 8'hBF);
            apb(1, gpp_pkg::IDX_P0_CFG + 6'(2 + i), im[m]);
            @(posedge clk_sys);
            ext_val[2 + i] <= 1'b1;
            see_irq(i, im[m] == 8'h40);
            @(posedge clk_sys);
            ext_val[2 + i] <= 1'b0;
            see_irq(i, im[m] == 8'h60);
         end
      end
      ext_en[7]   <= 1'b0;
      ext_en[15]  <= 1'b1;
      ext_val[15] <= 1'b0;
      apb(1, gpp_pkg::IDX_PORT0_DATA, 8'h00);
      apb(1, gpp_pkg::IDX_P0_CFG + 6'h07, 8'h41);
      apb(1, gpp_pkg::IDX_P1_CFG + 6'h07, 8'h40);
      @(posedge clk_sys);
      ext_val[15] <= 1'b1;
      see_irq(3, 1'b1);
      apb(1, gpp_pkg::IDX_PORT0_DATA, 8'h80);
      see_irq(3, 1'b0);
      apb(1, gpp_pkg::IDX_PORT0_DATA, 8'h00);
      @(posedge clk_sys);
      ext_val[15] <= 1'b0;
      see_irq(3, 1'b0);
      apb(1, gpp_pkg::IDX_PORT0_DATA, 8'h80);
      see_irq(3, 1'b1);
      apb(1, gpp_pkg::IDX_MODE, 8'h0B);
      apb(1, gpp_pkg::IDX_PORT1_DATA, 8'h02);
      apb(1, gpp_pkg::IDX_P1_CFG + 6'h02, 8'h80);
      `CHK({usb_mode, usb_force_en, usb_lines}, 4'hE)
      `CHK({regd[14:11], reg_en}, 5'h1F)
      apb(1, gpp_pkg::IDX_MODE, 8'h04);
      apb(1, gpp_pkg::IDX_P1_CFG + 6'h03, 8'h80);
      `CHK({pad_oe_n[11], pad_out[11]}, {~srl[4], srl[0]})
      stop_test();
   end
endmodule // gpp_gpio_port_test
